// *** design/uart_lfc_pkg.sv ***
package uart_lfc_pkg;

	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_IER  = 3'h1;
	localparam logic [2:0] IDX_LFC  = 3'h3;
	localparam logic [2:0] IDX_LSR  = 3'h5;

	// line_format_control field positions
	localparam int LFC_DIV_SEL  = 7;
	localparam int LFC_BREAK    = 6;
	localparam int LFC_STICK    = 5;
	localparam int LFC_EVEN     = 4;
	localparam int LFC_PAR_EN   = 3;
	localparam int LFC_STOP_EXT = 2;
	localparam int LFC_LEN_LSB  = 0;

	// line status field positions
	localparam int LSR_READY    = 0;
	localparam int LSR_PAR_ERR  = 2;
	localparam int LSR_FRM_ERR  = 3;
	localparam int LSR_THR_MT   = 5;
	localparam int LSR_TX_IDLE  = 6;

	localparam logic [7:0]  LFC_RESET = 8'h00;
	localparam logic [7:0]  IER_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0010;

	// data bits per character from the length field
	function automatic logic [3:0] char_bits(input logic [7:0] lfc);
		char_bits = 4'h5 + {2'h0, lfc[LFC_LEN_LSB +: 2]};
	endfunction : char_bits

	// zero the data bits above the character length
	function automatic logic [7:0] char_mask(input logic [7:0] d, input logic [7:0] lfc);
		char_mask = d & (8'hff >> (4'h8 - char_bits(lfc)));
	endfunction : char_mask

	// parity bit value for sending and for checking alike
	function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lfc);
		if (lfc[LFC_STICK])
			parity_of = ~lfc[LFC_EVEN];
		else
			parity_of = lfc[LFC_EVEN] ? ^char_mask(d, lfc) : ~^char_mask(d, lfc);
	endfunction : parity_of

endpackage : uart_lfc_pkg

// *** design/uart_tx_frame.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_tx_frame
	import uart_lfc_pkg::*;
(
	input  wire logic        clk,     // controller clock
	input  wire logic        resetn,  // async reset, active low
	input  wire logic        start,   // one-cycle request to send
	input  wire logic [7:0]  data,    // character to send
	input  wire logic [7:0]  lfc,     // line format at start
	input  wire logic [15:0] divisor, // clocks per bit
	output logic             busy,    // frame in progress
	output logic             line     // serial level before break
);
	typedef enum logic [4:0] {
		T_IDLE  = 5'b00001,
		T_START = 5'b00010,
		T_DATA  = 5'b00100,
		T_PAR   = 5'b01000,
		T_STOP  = 5'b10000
	} tx_state_t;

	tx_state_t   state_q;
	logic [16:0] cnt_q;
	logic [2:0]  bit_q;
	logic [7:0]  sh_q;
	logic [7:0]  cfg_q;
	logic [15:0] div_q;

	wire  [16:0] bit_end  = {1'b0, div_q} - 17'h00001;
	// one stop bit; with bit 2 set, 1.5 stop bits for 5-bit characters, else two
	wire  [16:0] stop_len = !cfg_q[LFC_STOP_EXT] ? {1'b0, div_q} :
	                        (cfg_q[LFC_LEN_LSB +: 2] == 2'h0) ? {1'b0, div_q} + {2'h0, div_q[15:1]} :
	                        {div_q, 1'b0}; // RULE_06
	wire         last     = (state_q == T_STOP) ? (cnt_q == stop_len - 17'h00001) : (cnt_q == bit_end);
	wire  [2:0]  top_bit  = 3'(char_bits(cfg_q) - 4'h1); // RULE_09

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= T_IDLE;
			cnt_q   <= 17'h00000;
			bit_q   <= 3'h0;
			sh_q    <= 8'h00;
			cfg_q   <= LFC_RESET;
			div_q   <= DIV_RESET;
			line    <= 1'b1;
			busy    <= 1'b0;
		end
		else
		begin
			cnt_q <= (state_q == T_IDLE || last) ? 17'h00000 : cnt_q + 17'h00001;
			case (state_q)
				T_IDLE:
					if (start)
					begin
						state_q <= T_START;
						sh_q    <= data;
						cfg_q   <= lfc;
						div_q   <= divisor;
						line    <= 1'b0;
						busy    <= 1'b1;
						bit_q   <= 3'h0;
					end
				T_START:
					if (last)
					begin
						state_q <= T_DATA;
						line    <= sh_q[0];
					end
				T_DATA:
					if (last)
					begin
						bit_q <= bit_q + 3'h1;
						if (bit_q == top_bit) // RULE_08
						begin
							// parity sits between last data bit and first stop bit
							state_q <= cfg_q[LFC_PAR_EN] ? T_PAR : T_STOP; // RULE_05
							line    <= cfg_q[LFC_PAR_EN] ? parity_of(sh_q, cfg_q) : 1'b1; // RULE_03 RULE_04
						end
						else
							line <= sh_q[bit_q + 3'h1];
					end
				T_PAR:
					if (last)
					begin
						state_q <= T_STOP;
						line    <= 1'b1;
					end
				T_STOP:
					if (last)
					begin
						state_q <= T_IDLE;
						busy    <= 1'b0;
					end
				default:
					state_q <= T_IDLE;
			endcase
		end
	end
endmodule : uart_tx_frame
`default_nettype wire

// *** design/uart_line_format_control.sv ***
// Operation
// RULE_01: divisor access select 1 maps shared addresses to divisor latches, else data and enables.
// RULE_02: break bit 6 holds the serial output low until software clears it.
// RULE_03: with bits 3 and 5 set, parity is fixed: 0 if bit 4 set, else 1.
// RULE_04: normal parity: bit 4 low odd, high even, over data plus parity.
// RULE_05: bit 3 adds a parity bit after the data, checked by the receiver.
// RULE_06: bit 2 gives 1.5 stop bits for 5-bit characters, two otherwise.
// RULE_07: receiver checks only the first stop bit.
// RULE_08: bits 1:0 select 5, 6, 7 or 8 data bits for both directions.
// RULE_09: character length counts data only; start, parity, stop are added.
// RULE_10: line format register is read/write and resets to zero.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module uart_line_format_control
	import uart_lfc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              clk,     // controller clock, 100 MHz
	input  wire logic              resetn,  // async reset, active low
	input  wire logic              psel,    // apb select
	input  wire logic              penable, // apb access phase
	input  wire logic              pwrite,  // apb direction
	input  wire logic [ADDR_W-1:0] paddr,   // apb byte address
	input  wire logic [31:0]       pwdata,  // apb write data
	output logic      [31:0]       prdata,  // apb read data
	output logic                   pready,  // apb ready
	output logic                   pslverr, // apb error, unmapped address
	input  wire logic              rxd,     // serial input
	output logic                   txd      // serial output
);
	// refused at elaboration: the decode needs index bits 4:2 and a zero test above them
	if (ADDR_W < 5)
	begin : g_addr_w_check
		$error("ADDR_W too small for the register map");
	end

	typedef enum logic [4:0] {
		R_IDLE  = 5'b00001,
		R_START = 5'b00010,
		R_DATA  = 5'b00100,
		R_PAR   = 5'b01000,
		R_STOP  = 5'b10000
	} rx_state_t;

	logic [7:0]  lfc_q;
	logic [7:0]  ier_q;
	logic [15:0] div_q;
	logic [7:0]  rbuf_q;
	logic        ready_q;
	logic        par_err_q;
	logic        frm_err_q;
	rx_state_t   rx_q;
	logic [15:0] rcnt_q;
	logic [2:0]  rbit_q;
	logic [7:0]  rsh_q;
	logic        rpar_q;
	logic        tx_busy;
	logic        tx_line;

	// apb decode
	wire         in_word  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
	wire  [2:0]  idx      = paddr[4:2];
	wire         hit_data = in_word && (idx == IDX_DATA);
	wire         hit_ier  = in_word && (idx == IDX_IER);
	wire         hit_lfc  = in_word && (idx == IDX_LFC);
	wire         hit_lsr  = in_word && (idx == IDX_LSR);
	wire         mapped   = hit_data || hit_ier || hit_lfc || hit_lsr;
	wire         dsel     = lfc_q[LFC_DIV_SEL];
	wire         access   = psel && penable && !pready;
	wire         done     = psel && penable && pready;
	wire         wr_done  = done && pwrite;
	wire         rd_done  = done && !pwrite;

	wire  [7:0]  lsr_val  = {1'b0, !tx_busy, !tx_busy, 1'b0, frm_err_q, par_err_q, 1'b0, ready_q};
	wire  [7:0]  rd_byte  = hit_data ? (dsel ? div_q[7:0] : rbuf_q) : // RULE_01
	                        hit_ier  ? (dsel ? div_q[15:8] : ier_q) :  // RULE_01
	                        hit_lfc  ? lfc_q :                         // RULE_10
	                        hit_lsr  ? lsr_val : 8'h00;

	wire         tx_start = wr_done && hit_data && !dsel && !tx_busy; // RULE_01
	wire         rb_read  = rd_done && hit_data && !dsel;
	wire         ls_read  = rd_done && hit_lsr;

	// one wait state: data registered during the first access cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= access;
			prdata  <= (access && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr <= access && !mapped;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lfc_q <= LFC_RESET; // RULE_10
			ier_q <= IER_RESET;
			div_q <= DIV_RESET;
		end
		else if (wr_done)
		begin
			if (hit_lfc)
				lfc_q <= pwdata[7:0]; // RULE_10
			if (hit_ier && !dsel)
				ier_q <= pwdata[7:0];
			if (hit_data && dsel)
				div_q[7:0] <= pwdata[7:0]; // RULE_01
			if (hit_ier && dsel)
				div_q[15:8] <= pwdata[7:0]; // RULE_01
		end
	end

	uart_tx_frame u_tx (
		.clk     (clk),
		.resetn  (resetn),
		.start   (tx_start),
		.data    (pwdata[7:0]),
		.lfc     (lfc_q),
		.divisor (div_q),
		.busy    (tx_busy),
		.line    (tx_line)
	);

	// break overrides the frame without stopping it; the frame runs on unseen
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			txd <= 1'b1;
		else
			txd <= lfc_q[LFC_BREAK] ? 1'b0 : tx_line; // RULE_02
	end

	// receiver; length and parity follow the live register
	wire  [15:0] half_end = {1'b0, div_q[15:1]};
	wire  [15:0] bit_end  = div_q - 16'h0001;
	wire         rtick    = (rx_q == R_START) ? (rcnt_q == half_end) : (rcnt_q == bit_end);
	wire  [2:0]  rtop     = 3'(char_bits(lfc_q) - 4'h1); // RULE_08 RULE_09
	wire  [7:0]  rdata    = rsh_q >> (4'h8 - char_bits(lfc_q));
	wire         got_char = (rx_q == R_STOP) && rtick;
	wire         par_bad  = lfc_q[LFC_PAR_EN] && (rpar_q != parity_of(rdata, lfc_q)); // RULE_03 RULE_04 RULE_05

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_q   <= R_IDLE;
			rcnt_q <= 16'h0000;
			rbit_q <= 3'h0;
			rsh_q  <= 8'h00;
			rpar_q <= 1'b0;
		end
		else
		begin
			rcnt_q <= (rx_q == R_IDLE || rtick) ? 16'h0000 : rcnt_q + 16'h0001;
			case (rx_q)
				R_IDLE:
					if (!rxd)
						rx_q <= R_START;
				R_START:
					if (rtick)
					begin
						rx_q   <= rxd ? R_IDLE : R_DATA;
						rbit_q <= 3'h0;
					end
				R_DATA:
					if (rtick)
					begin
						rsh_q  <= {rxd, rsh_q[7:1]};
						rbit_q <= rbit_q + 3'h1;
						if (rbit_q == rtop)
							rx_q <= lfc_q[LFC_PAR_EN] ? R_PAR : R_STOP; // RULE_05
					end
				R_PAR:
					if (rtick)
					begin
						rpar_q <= rxd;
						rx_q   <= R_STOP;
					end
				R_STOP:
					// only the first stop bit is sampled, then idle again
					if (rtick)
						rx_q <= R_IDLE; // RULE_07
				default:
					rx_q <= R_IDLE;
			endcase
		end
	end

	// set wins over a clearing read in the same cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rbuf_q    <= 8'h00;
			ready_q   <= 1'b0;
			par_err_q <= 1'b0;
			frm_err_q <= 1'b0;
		end
		else
		begin
			if (got_char)
				rbuf_q <= rdata;
			ready_q   <= got_char || (ready_q && !rb_read);
			par_err_q <= (got_char && par_bad) || (par_err_q && !ls_read);
			frm_err_q <= (got_char && !rxd) || (frm_err_q && !ls_read); // RULE_07
		end
	end
endmodule : uart_line_format_control
`default_nettype wire

// *** sim/uart_lfc_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_lfc_sva #(
	parameter int ADDR_W = 12
)
(
	input wire logic              clk,     // clock
	input wire logic              resetn,  // reset
	input wire logic              psel,    // apb
	input wire logic              penable, // apb
	input wire logic              pwrite,  // apb
	input wire logic [ADDR_W-1:0] paddr,   // apb
	input wire logic [31:0]       pwdata,  // apb
	input wire logic [31:0]       prdata,  // apb
	input wire logic              pready,  // apb
	input wire logic              pslverr, // apb
	input wire logic              rxd,     // serial in
	input wire logic              txd      // serial out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [7:0] lfc_q;
	logic [7:0] div_q;
	wire        done   = psel & penable & pready & ~pslverr;
	wire        rd_lfc = done & ~pwrite & (paddr == ADDR_W'(12'h00c));
	wire        rd_div = done & ~pwrite & (paddr == ADDR_W'(12'h000)) & lfc_q[7];
	wire        unmapped = (paddr != ADDR_W'(12'h000)) & (paddr != ADDR_W'(12'h004)) &
	                       (paddr != ADDR_W'(12'h00c)) & (paddr != ADDR_W'(12'h014));
	// shadow copies so read data can be tied to what was written
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			lfc_q <= 8'h00;
			div_q <= 8'h10;
		end
		else
		begin
			lfc_q <= (done & pwrite & (paddr == ADDR_W'(12'h00c))) ? pwdata[7:0] : lfc_q;
			div_q <= (done & pwrite & (paddr == ADDR_W'(12'h000)) & lfc_q[7]) ? pwdata[7:0] : div_q;
		end
	AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready held");
	AST_UNMAPPED: assert property (pready && unmapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped accepted");
	AST_MAPPED_OK: assert property (pready && !unmapped |-> !pslverr)
		else $error("mapped access flagged");
	AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready");
	AST_LFC_READ: assert property (rd_lfc |-> prdata == {24'h0, lfc_q})
		else $error("format readback");
	AST_DIV_READ: assert property (rd_div |-> prdata == {24'h0, div_q})
		else $error("divisor readback");
	AST_BREAK: assert property (lfc_q[6] && $past(lfc_q[6]) |-> !txd)
		else $error("break not held");
	AST_BIT_HOLD: assert property ($fell(txd) && !lfc_q[6] |-> !txd [*8])
		else $error("low bit too short");
endmodule : uart_lfc_sva
`default_nettype wire

// *** sim/uart_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_peer #(
	parameter int DIV = 18
)
(
	input  wire logic clk, // clock
	input  wire logic txd, // from device
	output var logic  rxd  // to device
);
	realtime t_fall;
	initial rxd = 1'b1;
	// mid-bit sampling, lsb first after start
	task automatic get(input int n, output logic [9:0] b);
		@(negedge txd);
		t_fall = $realtime;
		repeat (DIV / 2) @(posedge clk);
		b = 10'h000;
		for (int i = 0; i < n; i++)
		begin
			repeat (DIV) @(posedge clk);
			b[i] = txd;
		end
	endtask : get
	// line stays at the last bit, so back-to-back frames need no gap
	task automatic put(input logic [10:0] b, input int n);
		rxd <= 1'b0;
		repeat (DIV) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			rxd <= b[i];
			repeat (DIV) @(posedge clk);
		end
	endtask : put
endmodule : uart_peer
`default_nettype wire

// *** sim/uart_line_format_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_line_format_control_tb;
	import uart_lfc_pkg::*;
	localparam int DIV = 18;
	logic        clk;
	logic        resetn  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire         rxd;
	wire         txd;
	logic [31:0] rv;
	logic        ev;
	// data, parity, stop and one idle bit: up to eleven bits
	logic [10:0] v;
	logic [9:0]  b;
	int          k;
	int          errors;
	int          tests_run;
	int          cyc;
	logic [7:0]  txf [7] = '{8'h00, 8'h04, 8'h07, 8'h0b, 8'h1a, 8'h2d, 8'h3a};
	logic [31:0] rxc [5] = '{32'h1b5c6101, 32'h1ba36511, 32'h3b0f6101, 32'h00ff6900, 32'h2e556511};
	uart_line_format_control dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
	uart_peer #(.DIV(DIV)) peer_u (.clk(clk), .txd(txd), .rxd(rxd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends a wait
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// bits after start: data, parity, stop, then one idle bit
	task automatic frame(input logic [7:0] d, input logic [7:0] f, input logic flip, input logic stop);
		logic [7:0] m;
		m = d & (8'hff >> (3 - f[1:0]));
		v = {3'h0, m};
		k = 5 + f[1:0];
		if (f[3])
		begin
			v[k] = (f[5] ? ~f[4] : (f[4] ? ^m : ~^m)) ^ flip;
			k++;
		end
		v[k] = stop;
		v[k + 1] = 1'b1;
	endtask : frame
	initial
	begin
		int n;
		int t;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(0, 12'h00c, 8'h00);
		chk("lfc", rv, 32'h0);
		apb(0, 12'h014, 8'h00);
		chk("lsr", rv, 32'h60);
		apb(0, 12'h010, 8'h00);
		chk("unmapped", {rv[30:0], ev}, 32'h1);
		apb(1, 12'h00c, 8'h5b);
		apb(0, 12'h00c, 8'h00);
		chk("lfc", rv, 32'h5b);
		chk("txd", txd, 32'h0);
		apb(1, 12'h00c, 8'h80);
		apb(1, 12'h000, 8'(DIV));
		chk("txd", txd, 32'h1);
		apb(1, 12'h004, 8'h00);
		apb(1, 12'h00c, 8'h00);
		apb(1, 12'h004, 8'h0f);
		apb(1, 12'h00c, 8'h80);
		apb(0, 12'h000, 8'h00);
		chk("div_lo", rv, DIV);
		apb(0, 12'h004, 8'h00);
		chk("div_hi", rv, 32'h0);
		apb(1, 12'h00c, 8'h00);
		apb(0, 12'h004, 8'h00);
		chk("ier", rv, 32'h0f);
		foreach (txf[i])
		begin
			apb(1, 12'h00c, txf[i]);
			frame(8'h35 + 8'(i * 75), txf[i], 1'b0, 1'b1);
			fork
				peer_u.get(k + 1, b);
				apb(1, 12'h000, 8'h35 + 8'(i * 75));
			join
			chk("tx_bits", b, v & (10'h3ff >> (9 - k)));
			n = 0;
			do
			begin
				apb(0, 12'h014, 8'h00);
				n++;
			end
			while (rv[6] !== 1'b1 && n < 100);
			t = int'(($realtime - peer_u.t_fall) / 10.0) - DIV * (k + 2);
			t = t - (txf[i][2] ? ((txf[i][1:0] == 2'h0) ? DIV / 2 : DIV) : 0);
			chk("tx_len", t > -4 && t < 7, 32'h1);
		end
		foreach (rxc[i])
		begin
			apb(1, 12'h00c, rxc[i][31:24]);
			frame(rxc[i][23:16], rxc[i][31:24], rxc[i][4], rxc[i][0]);
			peer_u.put(v, k + 2);
			apb(0, 12'h014, 8'h00);
			chk("rx_lsr", rv, rxc[i][15:8]);
			apb(0, 12'h000, 8'h00);
			chk("rx_data", rv, rxc[i][23:16] & (8'hff >> (3 - rxc[i][25:24])));
			apb(0, 12'h014, 8'h00);
			chk("rx_clr", rv, 32'h60);
		end
		apb(1, 12'h00c, 8'h07);
		frame(8'h3c, 8'h07, 1'b0, 1'b1);
		peer_u.put(v, k + 1);
		peer_u.put(v, k + 2);
		apb(0, 12'h014, 8'h00);
		chk("rx_one_stop", rv, 32'h61);
		end_sim();
	end
endmodule : uart_line_format_control_tb
bind uart_line_format_control uart_lfc_sva #(.ADDR_W(ADDR_W)) sva_u (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxd(rxd), .txd(txd));
`default_nettype wire
